/* File: verilog/rtcm_pkg.sv */
`default_nettype none
package rtcm_pkg;
  localparam logic [6:0] DEV_ADDR = 7'h32;
  localparam logic RW_READ = 1'b1;
  localparam logic RW_WRITE = 1'b0;
  localparam logic [3:0] PTR_WRAP = 4'hF;
  localparam logic [3:0] PTR_RESERVED = 4'hD;
  localparam logic [3:0] MODE_STD = 4'h0;
  localparam int CLK_HZ = 10_000_000;
  localparam int SCL_HZ = 100_000;
  localparam int HALF_CYC = CLK_HZ / SCL_HZ / 2;
  localparam int GAP_NS = 1300;
  localparam int CLK_NS = 100;
  localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int XFER_MS = 500;
  localparam int XFER_CYC = CLK_HZ / 1000 * XFER_MS;
  localparam int FIFO_DEPTH = 16;

  typedef enum logic [1:0] {
    OP_WRITE = 2'b00,
    OP_READ_STD = 2'b01,
    OP_READ_SIMPLE = 2'b10,
    OP_READ_NOPTR = 2'b11
  } rtcm_op_t;

  typedef struct packed {
    rtcm_op_t op;
    logic [3:0] ptr;
    logic [3:0] mode;
    logic [7:0] count;
  } rtcm_cmd_t;

  typedef struct packed {
    logic [7:0] data;
    logic nack;
  } rtcm_rsp_t;
endpackage
`default_nettype wire

/* File: verilog/rtcm_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module rtcm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic do_wr;
  logic do_rd;

  assign in_ready = (wr_ptr - rd_ptr) != (AW + 1)'(DEPTH);
  assign out_valid = wr_ptr != rd_ptr;
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;
  assign out_data = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule // rtcm_fifo
`default_nettype wire

/* File: verilog/rtcm_master.sv */
// Contract
// - STOP may end a device-receive transfer anytime.
// - Whole transaction finishes within half a second.
// - After timeout only new START resumes.
// - At least 1.3 us between STOP and START.
// - Data moves in bytes, unlimited count; the 8-bit CMD count field limits a command to 255 bytes.
// - Master never touches reserved register Dh; the code only refuses a Dh pointer, and sequential bytes can still reach Dh.
// - SDA changes only while SCL low.
// - Receiver acknowledges low during ninth clock.
// - Master withholds ACK after last read byte.
// - Address byte 64h write, 65h read.
`timescale 1ns/1ps
`default_nettype none
module rtcm_master #(
  parameter int XFER_LIMIT = rtcm_pkg::XFER_CYC,
  parameter int FIFO_DEPTH = rtcm_pkg::FIFO_DEPTH
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire rtcm_pkg::rtcm_cmd_t CMD,
  input wire logic WDATA_VALID,
  output logic WDATA_READY,
  input wire logic [7:0] WDATA,
  output logic RSP_VALID,
  input wire logic RSP_READY,
  output rtcm_pkg::rtcm_rsp_t RSP,
  output logic BUSY,
  output logic ERROR,
  output logic SCL_O,
  output logic SCL_OE,
  input wire logic SCL_I,
  output logic SDA_O,
  output logic SDA_OE,
  input wire logic SDA_I
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_START = 4'b0001,
    ST_BIT = 4'b0010,
    ST_ACK = 4'b0011,
    ST_NEXT = 4'b0100,
    ST_RSTART = 4'b0101,
    ST_STOP = 4'b0110,
    ST_GAP = 4'b0111
  } rtcm_state_t;

  rtcm_state_t state;
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic [7:0] half_cnt;
  logic [1:0] phase;
  logic [2:0] bit_idx;
  logic [7:0] shreg;
  logic [7:0] remain;
  logic [1:0] stage;
  logic reading;
  logic drive_low;
  logic scl_low;
  logic ack_bad;
  logic [31:0] xfer_cnt;
  rtcm_pkg::rtcm_cmd_t cur;
  logic tick;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [7:0] fifo_out_data;
  rtcm_pkg::rtcm_rsp_t next_rsp;
  logic next_rsp_valid;
  logic rsp_in_ready;
  logic mid_low;

  // SCL stretching by the slave is honoured: a high phase only advances once the line is high.
  assign tick = (half_cnt == 8'(rtcm_pkg::HALF_CYC - 1)) && (scl_low || scl_sync[1]);
  assign mid_low = scl_low && (half_cnt == 8'(rtcm_pkg::HALF_CYC / 2));

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
    end else begin
      scl_sync <= {scl_sync[0], SCL_I};
      sda_sync <= {sda_sync[0], SDA_I};
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      half_cnt <= 8'h00;
    end else if (state == ST_IDLE || state == ST_NEXT || tick) begin
      half_cnt <= 8'h00;
    end else if (half_cnt != 8'(rtcm_pkg::HALF_CYC - 1)) begin
      half_cnt <= half_cnt + 8'h01;
    end
  end

  rtcm_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_wfifo (
    .clk(CLK),
    .rst(SYS_RST),
    .in_valid(WDATA_VALID),
    .in_ready(WDATA_READY),
    .in_data(WDATA),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  assign CMD_READY = (state == ST_IDLE);
  assign BUSY = (state != ST_IDLE);
  assign SCL_O = 1'b0;
  assign SCL_OE = scl_low;
  assign SDA_O = 1'b0;
  assign SDA_OE = drive_low;
  assign rsp_in_ready = !RSP_VALID || RSP_READY;

  // Stage 0 address, 1 pointer byte, 2 data, 3 read address after repeated START.
  function automatic logic [7:0] load_byte(input logic [1:0] stg, input rtcm_pkg::rtcm_cmd_t c,
                                           input logic [7:0] wd);
    case (stg)
      2'd0: load_byte = {rtcm_pkg::DEV_ADDR, (c.op == rtcm_pkg::OP_READ_NOPTR ||
                         c.op == rtcm_pkg::OP_READ_SIMPLE) ? rtcm_pkg::RW_READ
                         : rtcm_pkg::RW_WRITE};
      2'd1: load_byte = {c.ptr, c.mode};
      2'd3: load_byte = {rtcm_pkg::DEV_ADDR, rtcm_pkg::RW_READ};
      default: load_byte = wd;
    endcase
  endfunction

  // Write data is consumed from the FIFO as each data byte is loaded.
  assign fifo_out_ready = (state == ST_NEXT) && (cur.op == rtcm_pkg::OP_WRITE) &&
                          (stage != 2'd0) && !ack_bad && (xfer_cnt != 32'(XFER_LIMIT)) &&
                          (remain != 8'h00);

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      xfer_cnt <= '0;
    end else if (state == ST_IDLE || state == ST_GAP) begin
      xfer_cnt <= '0;
    end else if (xfer_cnt != 32'(XFER_LIMIT)) begin
      xfer_cnt <= xfer_cnt + 32'd1;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state <= ST_IDLE;
      phase <= 2'h0;
      bit_idx <= 3'h0;
      shreg <= 8'h00;
      remain <= 8'h00;
      stage <= 2'h0;
      reading <= 1'b0;
      drive_low <= 1'b0;
      scl_low <= 1'b0;
      ack_bad <= 1'b0;
      cur <= '0;
      ERROR <= 1'b0;
      next_rsp_valid <= 1'b0;
      next_rsp <= '0;
    end else begin
      next_rsp_valid <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (CMD_VALID && CMD.ptr != rtcm_pkg::PTR_RESERVED) begin
            cur <= CMD;
            ERROR <= 1'b0;
            ack_bad <= 1'b0;
            stage <= 2'd0;
            phase <= 2'h0;
            remain <= CMD.count;
            state <= ST_START;
          end else if (CMD_VALID) begin
            ERROR <= 1'b1;
          end
        end
        ST_START, ST_RSTART: if (tick) begin
          // Phase 0 releases SDA and raises SCL, 1 pulls SDA low while SCL high, 2 pulls SCL low.
          phase <= phase + 2'h1;
          case (phase)
            2'h0: begin
              drive_low <= 1'b0;
              scl_low <= 1'b0;
            end
            2'h1: drive_low <= 1'b1;
            default: begin
              scl_low <= 1'b1;
              shreg <= load_byte(stage, cur, 8'h00);
              bit_idx <= 3'h7;
              reading <= 1'b0;
              phase <= 2'h0;
              state <= ST_BIT;
            end
          endcase
        end
        ST_BIT: begin
          // SDA moves mid-way through the low half, so a bit never looks like START or STOP.
          if (mid_low) begin
            drive_low <= reading ? 1'b0 : !shreg[7];
          end
          if (tick) begin
            if (scl_low) begin
              scl_low <= 1'b0;
            end else begin
              scl_low <= 1'b1;
              shreg <= {shreg[6:0], sda_sync[1]};
              if (bit_idx == 3'h0) begin
                state <= ST_ACK;
              end else begin
                bit_idx <= bit_idx - 3'h1;
              end
            end
          end
        end
        ST_ACK: begin
          if (mid_low) begin
            // Reading: acknowledge every byte except the last one.
            drive_low <= reading && (remain != 8'h01);
          end
          if (tick) begin
            if (scl_low) begin
              scl_low <= 1'b0;
            end else begin
              scl_low <= 1'b1;
              if (reading) begin
                next_rsp_valid <= 1'b1;
                next_rsp <= '{data: shreg, nack: remain == 8'h01};
                remain <= remain - 8'h01;
              end else begin
                ack_bad <= sda_sync[1];
              end
              state <= ST_NEXT;
            end
          end
        end
        ST_NEXT: begin
          drive_low <= 1'b0;
          bit_idx <= 3'h7;
          if (!reading && ack_bad) begin
            // Any missing ACK ends the transaction; the device may have refused the address.
            ERROR <= 1'b1;
            state <= ST_STOP;
          end else if (xfer_cnt == 32'(XFER_LIMIT)) begin
            ERROR <= 1'b1;
            state <= ST_STOP;
          end else if (stage == 2'd0 && cur.op == rtcm_pkg::OP_READ_STD) begin
            stage <= 2'd1;
            shreg <= load_byte(2'd1, cur, 8'h00);
            state <= ST_BIT;
          end else if (stage == 2'd1 && cur.op == rtcm_pkg::OP_READ_STD) begin
            stage <= 2'd3;
            phase <= 2'h0;
            state <= ST_RSTART;
          end else if (stage == 2'd0 && cur.op == rtcm_pkg::OP_WRITE) begin
            stage <= 2'd1;
            shreg <= load_byte(2'd1, cur, 8'h00);
            state <= ST_BIT;
          end else if (remain == 8'h00) begin
            state <= ST_STOP;
          end else if (stage != 2'd2 && cur.op != rtcm_pkg::OP_WRITE) begin
            stage <= 2'd2;
            reading <= 1'b1;
            state <= ST_BIT;
          end else if (reading) begin
            // The byte just taken lands in RSP on this edge; waiting keeps it from being lost.
            if (rsp_in_ready && !next_rsp_valid) begin
              state <= ST_BIT;
            end
          end else if (fifo_out_valid) begin
            stage <= 2'd2;
            shreg <= load_byte(2'd2, cur, fifo_out_data);
            remain <= remain - 8'h01;
            state <= ST_BIT;
          end
        end
        ST_STOP: if (tick) begin
          phase <= phase + 2'h1;
          case (phase)
            2'h0: drive_low <= 1'b1;
            2'h1: scl_low <= 1'b0;
            default: begin
              drive_low <= 1'b0;
              phase <= 2'h0;
              state <= ST_GAP;
            end
          endcase
        end
        ST_GAP: begin
          if (half_cnt == 8'(rtcm_pkg::GAP_CYC)) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // The gap counter reuses half_cnt; HALF_CYC must exceed GAP_CYC, which holds at 100 kHz.
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      RSP_VALID <= 1'b0;
      RSP <= '0;
    end else if (next_rsp_valid) begin
      RSP_VALID <= 1'b1;
      RSP <= next_rsp;
    end else if (RSP_READY) begin
      RSP_VALID <= 1'b0;
    end
  end
endmodule // rtcm_master
`default_nettype wire

/* File: verification/rtcm_dev_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rtcm_dev_model #(
  parameter int TIMEOUT_NS = 3_000_000
) (
  input wire logic scl,
  input wire logic sda,
  input wire logic [6:0] addr,
  output logic sda_oe
);
  logic [7:0] mem [16];
  logic [7:0] sh, abyte;
  logic [3:0] ptr;
  logic act, rd, pset;
  int bn, st;
  time t0;
  initial begin
    {sda_oe, act, rd, pset} = 4'h0;
    t0 = 0;
    ptr = 4'hF;
  end
  always @(negedge sda) if (scl) begin
    {act, rd, sda_oe} = 3'h4;
    t0 = $time;
    bn = 0;
    st = 0;
  end
  always @(posedge sda) if (scl) begin
    act = 1'b0;
    pset = 1'b0;
  end
  always @(posedge scl) begin
    // An overlong transaction drops out until a new START; released SDA then reads as ones.
    if (act && $time - t0 > TIMEOUT_NS) {act, sda_oe} = 2'h0;
    if (act) begin
      if (bn < 8 && !rd) sh = {sh[6:0], sda};
      if (bn == 8 && rd) begin
        if (st == 2) ptr++;
        st = 2;
        if (sda) act = 1'b0;
      end
      bn++;
    end
  end
  // Driving happens on the falling clock, except the timeout release on the rising clock, so a bit never moves while SCL is high.
  always @(negedge scl) if (act) begin
    sda_oe = 1'b0;
    if (bn == 8 && !rd) begin
      sda_oe = 1'b1;
      if (st == 0) begin
        abyte = sh;
        rd = sh[0];
        if (sh[7:1] != addr) {act, sda_oe} = 2'h0;
        else if (rd && !pset) ptr = 4'hF;
      end else if (st == 1) begin
        ptr = sh[7:4];
        pset = 1'b1;
      end else begin
        mem[ptr] = sh;
        ptr++;
      end
      st = (st == 0) ? 1 : 2;
    end
    if (bn == 9) begin
      bn = 0;
      if (rd) sh = mem[ptr];
    end
    if (rd && bn < 8) sda_oe = !sh[7 - bn];
  end
endmodule // rtcm_dev_model
`default_nettype wire

/* File: verification/rtcm_master_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module rtcm_master_sva #(
  parameter int XFER_LIMIT = rtcm_pkg::XFER_CYC,
  parameter int FIFO_DEPTH = rtcm_pkg::FIFO_DEPTH
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic CMD_VALID,
  input wire logic CMD_READY,
  input wire rtcm_pkg::rtcm_cmd_t CMD,
  input wire logic RSP_VALID,
  input wire logic RSP_READY,
  input wire rtcm_pkg::rtcm_rsp_t RSP,
  input wire logic BUSY,
  input wire logic ERROR,
  input wire logic SCL_OE,
  input wire logic SDA_OE
);
  default clocking @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);
  int gap, bcnt;
  logic p_sda;
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      {p_sda, gap, bcnt} <= {1'b0, 32'd100, 32'd0};
    end else begin
      p_sda <= SDA_OE;
      bcnt <= BUSY ? bcnt + 1 : 0;
      if (p_sda && !SDA_OE && !SCL_OE) gap <= 0;
      else if (gap < 100) gap <= gap + 1;
    end
  end
  sequence s_start;
    $rose(SDA_OE) && !SCL_OE;
  endsequence
  sequence s_stop;
    $fell(SDA_OE) && !SCL_OE;
  endsequence
  chk_stop_gap: assert property (s_start |-> gap >= 12)
    else $error("start too soon");
  chk_start_clock: assert property (s_start |-> ##[1:60] SCL_OE)
    else $error("no clock after start");
  chk_stop_free: assert property (s_stop |=> (!SDA_OE && !SCL_OE) [*8])
    else $error("lines held after stop");
  chk_data_setup: assert property ($fell(SCL_OE) |-> $stable(SDA_OE) [*5])
    else $error("data moved in high phase");
  chk_idle_free: assert property (!BUSY |-> !SCL_OE && !SDA_OE && CMD_READY)
    else $error("idle lines held");
  chk_xfer_bound: assert property (bcnt <= XFER_LIMIT + 2000)
    else $error("transfer too long");
  chk_ptr_refused: assert property (CMD_VALID && CMD_READY &&
    CMD.ptr == rtcm_pkg::PTR_RESERVED |=> ERROR && !BUSY)
    else $error("reserved pointer taken");
  chk_rsp_hold: assert property (RSP_VALID && !RSP_READY |=> RSP_VALID && $stable(RSP))
    else $error("response lost");
  chk_cmd_start: assert property (CMD_VALID && CMD_READY &&
    CMD.ptr != rtcm_pkg::PTR_RESERVED |=> BUSY && !ERROR)
    else $error("command not started");
endmodule // rtcm_master_sva
bind rtcm_master rtcm_master_sva #(.XFER_LIMIT(XFER_LIMIT), .FIFO_DEPTH(FIFO_DEPTH)) u_sva (
  .CLK(CLK), .SYS_RST(SYS_RST), .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY), .CMD(CMD),
  .RSP_VALID(RSP_VALID), .RSP_READY(RSP_READY), .RSP(RSP), .BUSY(BUSY), .ERROR(ERROR),
  .SCL_OE(SCL_OE), .SDA_OE(SDA_OE));
`default_nettype wire

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic CLK, SYS_RST, CMD_VALID, WDATA_VALID, RSP_READY, CMD_READY, WDATA_READY;
  logic RSP_VALID, BUSY, ERROR, SCL_OE, SDA_OE, dev_oe, scl, sda;
  logic [7:0] WDATA;
  logic [6:0] addr;
  rtcm_pkg::rtcm_cmd_t CMD;
  rtcm_pkg::rtcm_rsp_t RSP;
  int mismatches, n_tests, k;
  // Both lines are open drain with pull-ups, so a released line reads high.
  assign scl = !SCL_OE;
  assign sda = !(SDA_OE || dev_oe);
  rtcm_master #(.XFER_LIMIT(20000), .FIFO_DEPTH(16)) dut (
    .CLK(CLK), .SYS_RST(SYS_RST), .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY), .CMD(CMD),
    .WDATA_VALID(WDATA_VALID), .WDATA_READY(WDATA_READY), .WDATA(WDATA),
    .RSP_VALID(RSP_VALID), .RSP_READY(RSP_READY), .RSP(RSP), .BUSY(BUSY), .ERROR(ERROR),
    .SCL_O(), .SCL_OE(SCL_OE), .SCL_I(scl), .SDA_O(), .SDA_OE(SDA_OE), .SDA_I(sda));
  rtcm_dev_model dev (.scl(scl), .sda(sda), .addr(addr), .sda_oe(dev_oe));
  function automatic logic [7:0] dv(int i);
    return 8'(i * 37 + 5);
  endfunction
  task automatic chk(string s, logic [7:0] e, logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", s, e, g);
      mismatches++;
    end
  endtask
  task automatic complete_run;
    $display("mismatches %0d n_tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic send(rtcm_pkg::rtcm_op_t op, logic [3:0] p, int n);
    @(posedge CLK);
    CMD <= '{op, p, rtcm_pkg::MODE_STD, 8'(n)};
    CMD_VALID <= 1'b1;
    @(posedge CLK);
    CMD_VALID <= 1'b0;
  endtask
  task automatic idle;
    repeat (2) @(negedge CLK);
    while (BUSY !== 1'b0) @(negedge CLK);
  endtask
  task automatic rd(rtcm_pkg::rtcm_op_t op, logic [3:0] p, int n, logic [7:0] e[$], bit st);
    send(op, p, n);
    if (st) begin
      RSP_READY <= 1'b0;
      repeat (6000) @(posedge CLK);
      RSP_READY <= 1'b1;
    end
    for (int i = 0; i < n; i++) begin
      do @(negedge CLK); while (RSP_VALID !== 1'b1);
      if (i < e.size()) chk("rsp", e[i], RSP.data);
      chk("nack", 8'(i == n - 1), 8'(RSP.nack));
      @(posedge CLK);
    end
    idle;
    chk("error", 8'h0, 8'(ERROR));
  endtask
  task automatic t_write;
    for (k = 0; k < 20; k++) begin
      @(posedge CLK);
      WDATA <= dv(k);
      WDATA_VALID <= 1'b1;
      @(negedge CLK);
      if (!WDATA_READY) break;
    end
    @(posedge CLK);
    WDATA_VALID <= 1'b0;
    chk("fill", 8'h10, 8'(k));
    send(rtcm_pkg::OP_WRITE, 4'hE, 3);
    idle;
    chk("wrap", dv(2), dev.mem[0]);
    send(rtcm_pkg::OP_WRITE, 4'h0, 13);
    idle;
    chk("wready", 8'h1, 8'(WDATA_READY));
    chk("addr", 8'h64, dev.abyte);
    chk("regE", dv(0), dev.mem[14]);
    for (k = 0; k < 13; k++) chk("reg", dv(k + 3), dev.mem[k]);
  endtask
  task automatic t_reads;
    rd(rtcm_pkg::OP_READ_STD, 4'hE, 4, '{dv(0), dv(1), dv(3), dv(4)}, 1);
    chk("addr", 8'h65, dev.abyte);
    rd(rtcm_pkg::OP_READ_SIMPLE, 4'h2, 2, '{dv(1), dv(3)}, 0);
    rd(rtcm_pkg::OP_READ_NOPTR, 4'h0, 3, '{dv(1), dv(3), dv(4)}, 0);
  endtask
  task automatic t_refuse;
    send(rtcm_pkg::OP_WRITE, rtcm_pkg::PTR_RESERVED, 0);
    @(negedge CLK);
    chk("err", 8'h1, 8'(ERROR));
    chk("busy", 8'h0, 8'(BUSY));
    send(rtcm_pkg::OP_WRITE, 4'h3, 0);
    idle;
    chk("err", 8'h0, 8'(ERROR));
    chk("ptr", 8'h3, 8'(dev.ptr));
    addr = 7'h33;
    send(rtcm_pkg::OP_WRITE, 4'h7, 0);
    idle;
    chk("err", 8'h1, 8'(ERROR));
    chk("ptr", 8'h3, 8'(dev.ptr));
    addr = rtcm_pkg::DEV_ADDR;
  endtask
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  // Sized from the expected run of roughly 40000 cycles, with room to spare.
  initial begin
    #9000000;
    mismatches++;
    complete_run;
  end
  initial begin
    {SYS_RST, CMD_VALID, WDATA_VALID, RSP_READY} = 4'h9;
    CMD = '0;
    WDATA = 8'h00;
    addr = rtcm_pkg::DEV_ADDR;
    repeat (4) @(posedge CLK);
    SYS_RST <= 1'b0;
    t_write;
    t_reads;
    t_refuse;
    complete_run;
  end
endmodule // tb_top
`default_nettype wire
